// ### design/logic_timer_block.sv
// eight scan-driven timer function blocks behind an axi4-lite slave
`timescale 1ns/1ps
module logic_timer_block
  import timer_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CNT_W = 16,
  parameter int SCAN_BASE_CYCLES = SCAN_BASE_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic [NUM_TIMERS-1:0] PRIMARY_IN,
  input wire logic [NUM_TIMERS-1:0] SECONDARY_IN,
  input wire logic [31:0] RTC_SECONDS,
  output logic [NUM_TIMERS-1:0] TIMER_OUT,
  output logic SCAN_TICK,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  if (ADDR_W < 12 || CNT_W < 2 || CNT_W > 32 || SCAN_BASE_CYCLES < 2) begin : bad_param
    $error("logic_timer_block: unsupported parameter value");
  end

  localparam logic [31:0] BASE_LAST = 32'(SCAN_BASE_CYCLES - 1);

  function automatic logic [3:0] scan_div(input logic [2:0] sel);
    logic [3:0] d;
    d = 4'h0;
    case (sel)
      SCAN_0P1: d = DIV_0P1;
      SCAN_0P2: d = DIV_0P2;
      SCAN_0P5: d = DIV_0P5;
      SCAN_1P0: d = DIV_1P0;
      default: d = 4'h0;
    endcase
    return d;
  endfunction

  function automatic logic is_global(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:4] == '0;
  endfunction

  function automatic logic is_timer(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:8] == (ADDR_W-8)'(TIMER_REGION));
  endfunction

  function automatic logic [2:0] unit_of(input logic [ADDR_W-1:0] a);
    return a[7:5];
  endfunction

  function automatic logic [2:0] field_of(input logic [ADDR_W-1:0] a);
    return a[4:2];
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] strb
  );
    logic [31:0] m;
    m = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return m;
  endfunction

  logic [2:0] scan_sel_r;
  logic [31:0] base_cnt_r;
  logic [3:0] pre_cnt_r;
  logic scan_tick_r;
  logic [31:0] cfg_r [NUM_TIMERS][NUM_FLD];
  logic [NUM_TIMERS-1:0] restart_r;
  logic [NUM_TIMERS-1:0] unit_out;
  logic [CNT_W-1:0] unit_stat [NUM_TIMERS];

  // scan divider; disabled selection holds the divider at zero and stops scan ticks
  wire [3:0] div = scan_div(scan_sel_r);
  wire scan_on = div != 4'h0;
  wire base_tick = scan_on & (base_cnt_r == BASE_LAST);
  // rate change mid-count must not let the prescaler run past its last step
  wire pre_last = pre_cnt_r >= (div - 4'h1);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      base_cnt_r <= 32'h0000_0000;
      pre_cnt_r <= 4'h0;
      scan_tick_r <= 1'b0;
    end else begin
      base_cnt_r <= (!scan_on || base_tick) ? 32'h0000_0000 : base_cnt_r + 32'h0000_0001;
      if (!scan_on || (base_tick && pre_last)) begin
        pre_cnt_r <= 4'h0;
      end else if (base_tick) begin
        pre_cnt_r <= pre_cnt_r + 4'h1;
      end
      scan_tick_r <= base_tick & pre_last;
    end
  end

  // write channel: address and data taken in either order
  logic aw_held_r, w_held_r, bvalid_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;

  wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID & S_AXI_WREADY;
  wire [ADDR_W-1:0] wr_addr = aw_held_r ? aw_addr_r : S_AXI_AWADDR;
  wire [31:0] wr_data = w_held_r ? w_data_r : S_AXI_WDATA;
  wire [3:0] wr_strb = w_held_r ? w_strb_r : S_AXI_WSTRB;
  wire wr_fire = (aw_held_r | aw_take) & (w_held_r | w_take) & ~bvalid_r;
  wire [2:0] wr_idx = unit_of(wr_addr);
  wire [2:0] wr_fld = field_of(wr_addr);
  wire wr_ctrl = is_global(wr_addr) & (wr_addr[3:2] == CTRL_OFS[3:2]);
  wire wr_cfg = is_timer(wr_addr) & (wr_fld != FLD_STATE);
  wire wr_ok = is_global(wr_addr) | is_timer(wr_addr);
  wire [31:0] ctrl_word = {29'h0000_0000, scan_sel_r};

  assign S_AXI_AWREADY = ~aw_held_r & ~bvalid_r;
  assign S_AXI_WREADY = ~w_held_r & ~bvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      aw_held_r <= ~wr_fire & (aw_held_r | aw_take);
      w_held_r <= ~wr_fire & (w_held_r | w_take);
      if (aw_take) begin
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read-only words accept writes silently, state is not touched
  wire [31:0] ctrl_merged = merge(ctrl_word, wr_data, wr_strb);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      scan_sel_r <= CTRL_RST;
      restart_r <= '0;
      for (int t = 0; t < NUM_TIMERS; t++) begin
        for (int f = 0; f < NUM_FLD; f++) begin
          cfg_r[t][f] <= CFG_RST;
        end
      end
    end else begin
      restart_r <= '0;
      if (wr_fire && wr_ctrl) begin
        scan_sel_r <= ctrl_merged[2:0];
      end
      if (wr_fire && wr_cfg) begin
        cfg_r[wr_idx][wr_fld] <= merge(cfg_r[wr_idx][wr_fld], wr_data, wr_strb);
        // mode write restarts the unit cleanly
        restart_r[wr_idx] <= wr_fld == FLD_MODE;
      end
    end
  end

  // read channel: one word per request, registered data
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  wire [ADDR_W-1:0] ra = S_AXI_ARADDR;
  wire [2:0] rd_idx = unit_of(ra);
  wire [2:0] rd_fld = field_of(ra);
  wire rd_ok = is_global(ra) | is_timer(ra);
  wire [31:0] stat_word = 32'(unit_stat[rd_idx]);
  wire [31:0] timer_word = (rd_fld == FLD_STATE) ? stat_word : cfg_r[rd_idx][rd_fld];
  wire [31:0] status_word = {24'h00_0000, TIMER_OUT};
  wire [31:0] input_word = {16'h0000, SECONDARY_IN, PRIMARY_IN};
  wire [31:0] glob_word =
    (ra[3:2] == CTRL_OFS[3:2]) ? ctrl_word :
    (ra[3:2] == STATUS_OFS[3:2]) ? status_word :
    (ra[3:2] == INPUT_OFS[3:2]) ? input_word :
    RTC_SECONDS;
  wire [31:0] rd_word = is_timer(ra) ? timer_word : (is_global(ra) ? glob_word : 32'h0000_0000);

  assign S_AXI_ARREADY = ~rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  for (genvar g = 0; g < NUM_TIMERS; g++) begin : tmr
    // each unit sees its own pair of inputs
    timer_unit #(
      .CNT_W(CNT_W)
    ) u_unit (
      .clk(CORE_CLK),
      .rstn(RSTN),
      .tick(scan_tick_r),
      .restart(restart_r[g]),
      .mode(mode_t'(cfg_r[g][FLD_MODE][2:0])),
      .p_in(PRIMARY_IN[g]),
      .s_in(SECONDARY_IN[g]),
      .dur(cfg_r[g][FLD_DUR][CNT_W-1:0]),
      .high_time(cfg_r[g][FLD_HIGH][CNT_W-1:0]),
      .period(cfg_r[g][FLD_PERIOD][CNT_W-1:0]),
      .preset(cfg_r[g][FLD_PRESET][CNT_W-1:0]),
      .trig(cfg_r[g][FLD_TRIG]),
      .intv(cfg_r[g][FLD_INTV]),
      .rtc(RTC_SECONDS),
      .out(unit_out[g]),
      .stat(unit_stat[g])
    );
  end

  // inputs read only at the scan tick, so short glitches are lost
  assign TIMER_OUT = unit_out;
  assign SCAN_TICK = scan_tick_r;

endmodule

// ### design/timer_pkg.sv
// shared constants and types for the logic timer block
package timer_pkg;

  localparam int NUM_TIMERS = 8;
  localparam int CLK_MHZ = 200;
  localparam int SCAN_BASE_MS = 100;
  localparam int SCAN_BASE_CYC = SCAN_BASE_MS * 1000 * CLK_MHZ;

  localparam logic [3:0] DIV_0P1 = 4'h1;
  localparam logic [3:0] DIV_0P2 = 4'h2;
  localparam logic [3:0] DIV_0P5 = 4'h5;
  localparam logic [3:0] DIV_1P0 = 4'hA;

  typedef enum logic [2:0] {
    SCAN_OFF = 3'b000,
    SCAN_0P1 = 3'b001,
    SCAN_0P2 = 3'b010,
    SCAN_0P5 = 3'b011,
    SCAN_1P0 = 3'b100
  } scan_t;

  typedef enum logic [2:0] {
    MODE_OFF_DELAY = 3'b000,
    MODE_ON_DELAY = 3'b001,
    MODE_REPEAT = 3'b010,
    MODE_SINGLE = 3'b011,
    MODE_RETRIG = 3'b100,
    MODE_INHIBIT = 3'b101,
    MODE_CLOCK = 3'b110,
    MODE_COUNTER = 3'b111
  } mode_t;

  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] INPUT_OFS = 12'h008;
  localparam logic [11:0] RTC_OFS = 12'h00C;
  localparam logic [3:0] TIMER_REGION = 4'h1;
  localparam int NUM_FLD = 7;
  localparam logic [2:0] FLD_MODE = 3'h0;
  localparam logic [2:0] FLD_DUR = 3'h1;
  localparam logic [2:0] FLD_HIGH = 3'h2;
  localparam logic [2:0] FLD_PERIOD = 3'h3;
  localparam logic [2:0] FLD_PRESET = 3'h4;
  localparam logic [2:0] FLD_TRIG = 3'h5;
  localparam logic [2:0] FLD_INTV = 3'h6;
  localparam logic [2:0] FLD_STATE = 3'h7;

  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### design/timer_unit.sv
// one timer function block, stepped once per scan tick
`timescale 1ns/1ps
module timer_unit
  import timer_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic restart,
  input wire mode_t mode,
  input wire logic p_in,
  input wire logic s_in,
  input wire logic [CNT_W-1:0] dur,
  input wire logic [CNT_W-1:0] high_time,
  input wire logic [CNT_W-1:0] period,
  input wire logic [CNT_W-1:0] preset,
  input wire logic [31:0] trig,
  input wire logic [31:0] intv,
  input wire logic [31:0] rtc,
  output logic out,
  output logic [CNT_W-1:0] stat
);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
  logic prev_r, prev_nxt, out_r, out_nxt, armed_r, armed_nxt;
  logic [CNT_W-1:0] el_r, el_nxt, cnt_r, cnt_nxt;
  logic [31:0] next_r, next_nxt;
  wire rise = p_in & ~prev_r;
  wire [CNT_W-1:0] el_inc = (el_r == '1) ? el_r : el_r + ONE;
  wire dur_done = el_inc >= dur;
  wire [CNT_W-1:0] el_wrap = (el_inc >= period) ? '0 : el_inc;
  wire cnt_le0 = cnt_r[CNT_W-1] | (cnt_r == '0);
  wire rtc_hit = armed_r & (rtc >= next_r);

  always_comb begin
    prev_nxt = prev_r;
    out_nxt = out_r;
    el_nxt = el_r;
    cnt_nxt = cnt_r;
    armed_nxt = armed_r;
    next_nxt = next_r;
    if (restart) begin
      prev_nxt = p_in;
      out_nxt = 1'b0;
      el_nxt = '0;
      cnt_nxt = preset;
      armed_nxt = 1'b1;
      next_nxt = trig;
    end else if (tick) begin
      prev_nxt = p_in;
      unique case (mode)
        MODE_OFF_DELAY: begin
          if (p_in) begin
            out_nxt = 1'b1;
            el_nxt = '0;
          end else if (out_r) begin
            el_nxt = el_inc;
            out_nxt = ~dur_done;
          end
        end
        MODE_ON_DELAY: begin
          if (!p_in) begin
            out_nxt = 1'b0;
            el_nxt = '0;
          end else if (!out_r) begin
            el_nxt = el_inc;
            out_nxt = dur_done;
          end
        end
        MODE_REPEAT: begin
          if (!p_in) begin
            out_nxt = 1'b0;
            el_nxt = '0;
          end else if (rise) begin
            out_nxt = high_time != '0;
            el_nxt = '0;
          end else begin
            el_nxt = el_wrap;
            out_nxt = el_wrap < high_time;
          end
        end
        MODE_SINGLE, MODE_INHIBIT: begin
          if (rise && !out_r) begin
            out_nxt = dur != '0;
            el_nxt = '0;
          end else if (out_r && !(mode == MODE_INHIBIT && s_in)) begin
            el_nxt = el_inc;
            out_nxt = ~dur_done;
          end
        end
        MODE_RETRIG: begin
          if (rise) begin
            out_nxt = dur != '0;
            el_nxt = '0;
          end else if (out_r) begin
            el_nxt = el_inc;
            out_nxt = ~dur_done;
          end
        end
        MODE_CLOCK: begin
          if (rtc_hit) begin
            out_nxt = dur != '0;
            el_nxt = '0;
            armed_nxt = intv != 32'h0000_0000;
            next_nxt = next_r + intv;
          end else if (out_r) begin
            el_nxt = el_inc;
            out_nxt = ~dur_done;
          end
        end
        MODE_COUNTER: begin
          if (s_in) begin
            out_nxt = 1'b0;
            cnt_nxt = preset;
          end else begin
            out_nxt = cnt_le0 | (rise & (cnt_r == ONE));
            if (!cnt_le0 && rise) begin
              cnt_nxt = cnt_r - ONE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_r <= 1'b0;
      out_r <= 1'b0;
      el_r <= '0;
      cnt_r <= '0;
      armed_r <= 1'b0;
      next_r <= 32'h0000_0000;
    end else begin
      prev_r <= prev_nxt;
      out_r <= out_nxt;
      el_r <= el_nxt;
      cnt_r <= cnt_nxt;
      armed_r <= armed_nxt;
      next_r <= next_nxt;
    end
  end

  assign out = out_r;
  assign stat = (mode == MODE_COUNTER) ? cnt_r : el_r;
endmodule

// ### tb/logic_timer_props.sv
// port checker for the logic timer block
`timescale 1ns/1ps
module logic_timer_props
  import timer_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic [NUM_TIMERS-1:0] TIMER_OUT,
  input wire logic SCAN_TICK,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  a_out_rise_tick:
  assert property (|(TIMER_OUT & ~$past(TIMER_OUT)) |-> $past(SCAN_TICK))
    else $error("timer output rose without a scan tick");
  a_tick_single_gap:
  assert property (SCAN_TICK |=> !SCAN_TICK [*8])
    else $error("scan ticks closer than the base period");
  a_b_holds:
  assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before taken");
  a_r_holds:
  assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA)
    && $stable(S_AXI_RRESP))
    else $error("read data dropped before taken");
  a_b_blocks_req:
  assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write channels ready during response");
  a_r_answer_next:
  assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer not on next cycle");
  a_b_release_ready:
  assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY)
    else $error("write channel not free after response");
  a_r_release_ready:
  assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
    else $error("read channel not free after response");
  c_tick: cover property (SCAN_TICK);
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_read_err: cover property (S_AXI_RVALID && S_AXI_RREADY && S_AXI_RRESP == RESP_SLVERR);
  c_out: cover property (|TIMER_OUT);
endmodule
bind logic_timer_block logic_timer_props props_u (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .TIMER_OUT(TIMER_OUT), .SCAN_TICK(SCAN_TICK),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
);

// ### tb/scan_driver.sv
// logic program model: plays level patterns on one timer, one bit per scan
`timescale 1ns/1ps
module scan_driver
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic go,
  input wire logic [2:0] sel,
  input wire logic [31:0] p_pat,
  input wire logic [31:0] s_pat,
  output logic [NUM_TIMERS-1:0] p_out,
  output logic [NUM_TIMERS-1:0] s_out,
  output logic done
);
  logic [5:0] step_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_r <= '0;
      p_out <= '0;
      s_out <= '0;
      done <= 1'b0;
    end else if (!go) begin
      step_r <= '0;
      done <= 1'b0;
    end else if (tick && !done) begin
      // levels move only on a tick, one lane
      p_out <= NUM_TIMERS'(p_pat[step_r[4:0]]) << sel;
      s_out <= NUM_TIMERS'(s_pat[step_r[4:0]]) << sel;
      step_r <= step_r + 6'h01;
      done <= (step_r == 6'h1F);
    end
  end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the logic timer block
`timescale 1ns/1ps
module tb_top
  import timer_pkg::*;
;
  // short scan base keeps the run small
  localparam int BASE = 10;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rtc = '0, rdata, p_pat = '0, s_pat = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tick, done, go = 1'b0;
  logic [1:0] bresp, rresp;
  logic [7:0] t_out, p_in, s_in;
  logic [2:0] sel = '0;
  int n_fail = 0;
  int samples_checked = 0;
  int dv[5] = '{0, DIV_0P1, DIV_0P2, DIV_0P5, DIV_1P0};
  always #2.5 clk = ~clk;
  logic_timer_block #(.SCAN_BASE_CYCLES(BASE)) dut_u (
    .CORE_CLK(clk), .RSTN(rstn), .PRIMARY_IN(p_in), .SECONDARY_IN(s_in),
    .RTC_SECONDS(rtc), .TIMER_OUT(t_out), .SCAN_TICK(tick),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  scan_driver drv_u (.clk(clk), .rstn(rstn), .tick(tick), .go(go), .sel(sel), .p_pat(p_pat),
    .s_pat(s_pat), .p_out(p_in), .s_out(s_in), .done(done));
  task automatic report_and_stop();
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    n_fail++;
    $display("BAD %s expected answer seen timeout", nm);
    report_and_stop();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit b;
    b = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 50 && !b; k++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) b = 1;
    end
    bready <= 1'b0;
    if (!b) hang("write response");
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] er);
    bit r;
    r = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 50 && !r; k++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        r = 1;
        chk(nm, e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
      end
    end
    rready <= 1'b0;
    if (!r) hang("read data");
  endtask
  // timing fields first, mode last since the mode write restarts the timer
  task automatic cfg(input int i, input mode_t m, input int dur, hi, per, pre);
    logic [11:0] b;
    b = 12'h100 + 12'(32 * i);
    wr(b + 12'h004, 32'(dur), RESP_OKAY);
    wr(b + 12'h008, 32'(hi), RESP_OKAY);
    wr(b + 12'h00C, 32'(per), RESP_OKAY);
    wr(b + 12'h010, 32'(pre), RESP_OKAY);
    wr(b, 32'(m), RESP_OKAY);
  endtask
  // counts output-high cycles over a 32-scan pattern; negative skips the check
  task automatic play(input int i, input logic [31:0] pp, sp, input int scans);
    int n;
    n = 0;
    @(posedge clk);
    sel <= 3'(i);
    p_pat <= pp;
    s_pat <= sp;
    go <= 1'b1;
    for (int k = 0; k < 1000 && done !== 1'b1; k++) begin
      @(posedge clk);
      if (t_out[i] === 1'b1) n++;
    end
    go <= 1'b0;
    if (done !== 1'b1) hang("input pattern");
    if (scans >= 0) chk("pulse cycles", 32'(scans * BASE), 32'(n));
  endtask
  task automatic t_regs();
    int n;
    rdchk("ctrl reset", CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    rdchk("unmapped read", 12'h0F0, 32'h0000_0000, RESP_SLVERR);
    wr(12'h0F0, 32'h1234_5678, RESP_SLVERR);
    wr(STATUS_OFS, 32'hFFFF_FFFF, RESP_OKAY);
    rdchk("status", STATUS_OFS, 32'h0000_0000, RESP_OKAY);
    for (int s = 1; s <= 4; s++) begin
      wr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
      wr(CTRL_OFS, 32'(s), RESP_OKAY);
      n = 0;
      for (int k = 0; k < 2 * BASE * dv[s] + 5; k++) begin
        @(posedge clk);
        if (tick === 1'b1) n++;
      end
      chk("ticks in two periods", 32'h0000_0002, 32'(n));
    end
    wr(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
  endtask
  task automatic t_off_delay();
    cfg(0, MODE_OFF_DELAY, 3, 0, 0, 0);
    play(0, 32'h0000_0003, 32'h0000_000F, 4);
  endtask
  task automatic t_on_delay();
    cfg(1, MODE_ON_DELAY, 3, 0, 0, 0);
    play(1, 32'h0000_001F, 32'h0000_0003, 3);
  endtask
  task automatic t_repeat();
    cfg(2, MODE_REPEAT, 0, 2, 4, 0);
    play(2, 32'h0000_0FFF, 32'h0000_0000, 6);
  endtask
  task automatic t_single();
    cfg(3, MODE_SINGLE, 4, 0, 0, 0);
    play(3, 32'h0000_000B, 32'h0000_00FF, 4);
  endtask
  task automatic t_retrig();
    cfg(4, MODE_RETRIG, 3, 0, 0, 0);
    play(4, 32'h0000_0005, 32'h0000_0007, 5);
  endtask
  task automatic t_inhibit();
    cfg(5, MODE_INHIBIT, 3, 0, 0, 0);
    play(5, 32'h0000_0001, 32'h0000_0006, 5);
  endtask
  task automatic t_clock();
    wr(12'h1D4, 32'h0000_0005, RESP_OKAY);
    wr(12'h1D8, 32'h0000_0003, RESP_OKAY);
    cfg(6, MODE_CLOCK, 2, 0, 0, 0);
    @(posedge clk);
    rtc <= 32'h0000_0005;
    play(6, 32'h5555_5555, 32'hAAAA_AAAA, 2);
    @(posedge clk);
    rtc <= 32'h0000_0008;
    play(6, 32'hAAAA_AAAA, 32'h5555_5555, 2);
    rdchk("rtc word", RTC_OFS, 32'h0000_0008, RESP_OKAY);
  endtask
  task automatic t_counter();
    cfg(7, MODE_COUNTER, 0, 0, 0, 2);
    play(7, 32'h0000_0004, 32'h0000_0000, -1);
    rdchk("count after one edge", 12'h1FC, 32'h0000_0001, RESP_OKAY);
    rdchk("output low", STATUS_OFS, 32'h0000_0000, RESP_OKAY);
    play(7, 32'h0000_0054, 32'h0000_0000, -1);
    rdchk("count held", 12'h1FC, 32'h0000_0000, RESP_OKAY);
    rdchk("output set", STATUS_OFS, 32'h0000_0080, RESP_OKAY);
    play(7, 32'h0000_0000, 32'h0000_0001, -1);
    rdchk("count reloaded", 12'h1FC, 32'h0000_0002, RESP_OKAY);
    rdchk("output cleared", STATUS_OFS, 32'h0000_0000, RESP_OKAY);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_off_delay();
    t_on_delay();
    t_repeat();
    t_single();
    t_retrig();
    t_inhibit();
    t_clock();
    t_counter();
    report_and_stop();
  end
endmodule
